// ==== include/gpnm_pkg.sv ====
// constants, mode type and decode for the nine-mode gpio port
package gpnm_pkg;

    localparam int PIN_N = 8;

    // ==========================================================
    // register word offsets (byte addresses)
    localparam logic [7:0] OFS_DATA    = 8'h00;
    localparam logic [7:0] OFS_DIR     = 8'h04;
    localparam logic [7:0] OFS_MODE_LO = 8'h08;
    localparam logic [7:0] OFS_MODE_HI = 8'h0c;
    localparam logic [7:0] OFS_CLEAR   = 8'h10;
    localparam logic [7:0] OFS_PENDING = 8'h14;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_DATA    = 8'h00;
    localparam logic [7:0] RST_DIR     = 8'hff;
    localparam logic [7:0] RST_MODE_LO = 8'h00;
    localparam logic [7:0] RST_MODE_HI = 8'h00;
    localparam logic [7:0] RST_CLEAR   = 8'h00;
    localparam logic [7:0] ALT_IDLE    = 8'hff;

    // ==========================================================
    // pin modes
    typedef enum logic [3:0] {
        MODE_OUT,
        MODE_IN,
        MODE_OD,
        MODE_OS,
        MODE_RSV,
        MODE_DUAL,
        MODE_ALT,
        MODE_LEVEL,
        MODE_EDGE
    } gpnm_mode_e;

    function automatic gpnm_mode_e gpnm_mode(input logic hi, input logic lo,
                                             input logic dir, input logic dat);
        gpnm_mode_e m;
        m = MODE_IN;
        unique case ({hi, lo, dir})
            3'b000: m = MODE_OUT;
            3'b001: m = MODE_IN;
            3'b010: m = MODE_OD;
            3'b011: m = MODE_OS;
            3'b100: m = dat ? MODE_DUAL : MODE_RSV;
            3'b101: m = MODE_ALT;
            3'b110: m = MODE_LEVEL;
            3'b111: m = MODE_EDGE;
        endcase
        return m;
    endfunction

endpackage

// ==== hdl/gpnm_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module gpnm_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// ==== hdl/gpnm_edge_latch.sv ====
// per-pin edge detect and sticky request, set beats clear
`timescale 1ns/10ps
module gpnm_edge_latch #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] smp_i,
    input  wire logic [WIDTH-1:0] prv_i,
    input  wire logic [WIDTH-1:0] pol_i,
    input  wire logic [WIDTH-1:0] dual_i,
    input  wire logic [WIDTH-1:0] single_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] pend_o
);
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
    logic [WIDTH-1:0] set;

    assign rise = smp_i & ~prv_i;
    assign fall = ~smp_i & prv_i;
    assign set  = (dual_i & (rise | fall))
                | (single_i & ((pol_i & rise) | (~pol_i & fall)));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pend_o <= '0;
        else
            pend_o <= (pend_o & ~clr_i) | set;
    end
endmodule

// ==== hdl/gpnm_port.sv ====
// one 8-pin nine-mode gpio port with wishbone register slave
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module gpnm_port
    import gpnm_pkg::*;
#(
    parameter int         PIN_W    = PIN_N,
    parameter logic [7:0] ALT_REST = ALT_IDLE
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [PIN_W-1:0] pin_i,
    output logic      [PIN_W-1:0] pin_o,
    output logic      [PIN_W-1:0] pin_oe_o,
    input  wire logic [PIN_W-1:0] alt_out_i,
    input  wire logic [PIN_W-1:0] alt_oe_i,
    output logic      [PIN_W-1:0] alt_in_o,
    output logic      [PIN_W-1:0] irq_o
);
    // ==========================================================
    // registers and sampled pins
    logic [PIN_W-1:0] data_q;
    logic [PIN_W-1:0] dir_q;
    logic [PIN_W-1:0] mlo_q;
    logic [PIN_W-1:0] mhi_q;
    logic [PIN_W-1:0] smp;
    logic [PIN_W-1:0] prv_q;
    logic [PIN_W-1:0] match;
    logic [PIN_W-1:0] match_q;
    logic [PIN_W-1:0] pend;
    logic [PIN_W-1:0] clr;
    logic             req;
    logic             wr;
    logic [31:0]      rd_d;

    // ==========================================================
    // per-pin mode masks
    gpnm_mode_e       mode [PIN_W];
    logic [PIN_W-1:0] m_out;
    logic [PIN_W-1:0] m_od;
    logic [PIN_W-1:0] m_os;
    logic [PIN_W-1:0] m_alt;
    logic [PIN_W-1:0] m_dual;
    logic [PIN_W-1:0] m_lvl;
    logic [PIN_W-1:0] m_edge;
    logic [PIN_W-1:0] oe_d;
    logic [PIN_W-1:0] o_d;

    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            mode[i]   = gpnm_mode(mhi_q[i], mlo_q[i], dir_q[i], data_q[i]);
            m_out[i]  = (mode[i] == MODE_OUT);
            m_od[i]   = (mode[i] == MODE_OD);
            m_os[i]   = (mode[i] == MODE_OS);
            m_alt[i]  = (mode[i] == MODE_ALT);
            m_dual[i] = (mode[i] == MODE_DUAL);
            m_lvl[i]  = (mode[i] == MODE_LEVEL);
            m_edge[i] = (mode[i] == MODE_EDGE);
        end
    end

    // ==========================================================
    // wishbone slave, one wait state
    assign req = wb_cyc_i & wb_stb_i;
    assign wr  = req & wb_we_i & wb_ack_o & wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req & ~wb_ack_o;
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_DATA:    rd_d[PIN_W-1:0] = smp;
            OFS_DIR:     rd_d[PIN_W-1:0] = dir_q;
            OFS_MODE_LO: rd_d[PIN_W-1:0] = mlo_q;
            OFS_MODE_HI: rd_d[PIN_W-1:0] = mhi_q;
            OFS_PENDING: rd_d[PIN_W-1:0] = pend;
            default:     rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req & ~wb_ack_o)
            wb_dat_o <= rd_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_q <= RST_DATA;
            dir_q  <= RST_DIR;
            mlo_q  <= RST_MODE_LO;
            mhi_q  <= RST_MODE_HI;
        end
        else if (wr)
        begin
            if (wb_adr_i == OFS_DATA)
                data_q <= wb_dat_i[PIN_W-1:0];
            if (wb_adr_i == OFS_DIR)
                dir_q <= wb_dat_i[PIN_W-1:0];
            if (wb_adr_i == OFS_MODE_LO)
                mlo_q <= wb_dat_i[PIN_W-1:0];
            if (wb_adr_i == OFS_MODE_HI)
                mhi_q <= wb_dat_i[PIN_W-1:0];
        end
    end

    assign clr = (wr && wb_adr_i == OFS_CLEAR) ? wb_dat_i[PIN_W-1:0] : RST_CLEAR;

    // ==========================================================
    // pin sampling
    gpnm_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pin_i),
        .sync_o  (smp)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prv_q   <= '0;
            match_q <= '0;
        end
        else
        begin
            prv_q   <= smp;
            match_q <= match;
        end
    end

    assign match = ~(smp ^ data_q);

    // ==========================================================
    // pin drivers
    always_comb
    begin
        oe_d = '0;
        o_d  = '0;
        for (int i = 0; i < PIN_W; i++)
        begin
            if (m_out[i])
            begin
                oe_d[i] = 1'b1;
                o_d[i]  = data_q[i];
            end
            else if (m_od[i])
                oe_d[i] = ~data_q[i];
            else if (m_os[i])
            begin
                oe_d[i] = data_q[i];
                o_d[i]  = 1'b1;
            end
            else if (m_alt[i])
            begin
                oe_d[i] = alt_oe_i[i];
                o_d[i]  = alt_out_i[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_oe_o <= '0;
            pin_o    <= '0;
        end
        else
        begin
            pin_oe_o <= oe_d;
            pin_o    <= o_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            alt_in_o <= ALT_REST[PIN_W-1:0];
        else
            alt_in_o <= (m_alt & smp) | (~m_alt & ALT_REST[PIN_W-1:0]);
    end

    // ==========================================================
    // interrupt requests
    // dual and single edge latch
    gpnm_edge_latch #(
        .WIDTH (PIN_W)
    ) u_edge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .smp_i    (smp),
        .prv_i    (prv_q),
        .pol_i    (data_q),
        .dual_i   (m_dual),
        .single_i (m_edge),
        .clr_i    (clr),
        .pend_o   (pend)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= '0;
        else
            irq_o <= ((m_dual | m_edge) & pend) | (m_lvl & match & match_q);
    end

    // ==========================================================
    // checks
    logic past_ok;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            past_ok <= 1'b0;
        else
            past_ok <= 1'b1;
    end

    sequence s_clear_write;
        wr && wb_adr_i == OFS_CLEAR && prv_q == smp;
    endsequence

    a_reset_input_mode: assert property (
        @(posedge clk_i) $past(rst_i) |-> (dir_q == RST_DIR && mlo_q == RST_MODE_LO
                                         && mhi_q == RST_MODE_HI && irq_o == '0))
        else $error("pins not in input mode after reset");

    a_read_pin_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_ack_o && wb_adr_i == OFS_DATA
            |=> wb_ack_o && wb_dat_o[PIN_W-1:0] == $past(smp))
        else $error("data read not the sampled pins");

    a_push_pull_drive: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        (($past(m_out) & ~pin_oe_o) | ($past(m_out) & (pin_o ^ $past(data_q)))) == '0)
        else $error("mode 1 pin not driving data");

    a_open_drain_low: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        ($past(m_od) & ((pin_oe_o ^ ~$past(data_q)) | (pin_oe_o & pin_o))) == '0)
        else $error("open drain drive wrong");

    a_open_source_high: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        ($past(m_os) & ((pin_oe_o ^ $past(data_q)) | (pin_oe_o & ~pin_o))) == '0)
        else $error("open source drive wrong");

    a_float_modes: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        ($past(~(m_out | m_od | m_os | m_alt)) & pin_oe_o) == '0)
        else $error("input or interrupt pin is driven");

    a_alt_passthru: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        ($past(m_alt) & ((pin_oe_o ^ $past(alt_oe_i)) | (pin_o ^ $past(alt_out_i)))) == '0)
        else $error("alternate function not on pin");

    a_alt_input_idle: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        ($past(~m_alt) & (alt_in_o ^ ALT_REST[PIN_W-1:0])) == '0
            && ($past(m_alt) & (alt_in_o ^ $past(smp))) == '0)
        else $error("alternate input wrong");

    a_level_hold_two: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        (irq_o & $past(m_lvl) & ~($past(match) & $past(match, 2))) == '0)
        else $error("level request without two matches");

    a_level_follows: assert property (
        @(posedge clk_i) disable iff (rst_i || !past_ok)
        (~irq_o & $past(m_lvl) & $past(match) & $past(match_q)) == '0)
        else $error("level request missing while matching");

    a_edge_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 (($past(pend) & ~pend & ~$past(clr)) == '0))
        else $error("edge request lost without clear");

    a_edge_clear_two: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_clear_write ##1 (prv_q == smp)[*2] |-> ##1 ((irq_o & $past(clr, 3)) == '0))
        else $error("edge request not cleared");

    a_edge_latch_seen: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((m_dual | m_edge) != '0 && (prv_q ^ smp) != '0)
            |=> ((pend | ~$past((prv_q ^ smp) & m_dual)) == '1))
        else $error("dual edge not latched");

endmodule

// ==== test/gpnm_pin_peer.sv ====
// pin-side model: external drivers, pull resistors, resolved pad level
`timescale 1ns/10ps
module gpnm_pin_peer (
    input  wire logic [7:0] dev_out_i,
    input  wire logic [7:0] dev_oe_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] pull_up_i,
    output logic      [7:0] pad_o
);
    // ==========================================================
    // pad resolution, contention shows as unknown
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (dev_oe_i[i] && ext_en_i[i])
                pad_o[i] = 1'bx;
            else if (dev_oe_i[i])
                pad_o[i] = dev_out_i[i];
            else if (ext_en_i[i])
                pad_o[i] = ext_val_i[i];
            else
                pad_o[i] = pull_up_i[i];
        end
    end
endmodule

// ==== test/gpio_port_nine_mode_tb_top.sv ====
// self-checking bench for the nine-mode gpio port
`timescale 1ns/10ps
module gpio_port_nine_mode_tb_top
    import gpnm_pkg::*;
();
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [3:0]  sel_val;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [7:0]  pin_i;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe_o;
    logic [7:0]  alt_out;
    logic [7:0]  alt_oe;
    logic [7:0]  alt_in_o;
    logic [7:0]  irq_o;
    logic [7:0]  ext_en;
    logic [7:0]  ext_val;
    logic [7:0]  pull;
    int          n_errors;
    int          comparisons;

    gpnm_port uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
        .alt_in_o(alt_in_o), .irq_o(irq_o));

    gpnm_pin_peer peer (.dev_out_i(pin_o), .dev_oe_i(pin_oe_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pull_up_i(pull), .pad_o(pin_i));

    // ==========================================================
    // helpers
    task automatic stop_test;
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        sel <= sel_val;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            chk(8'h00, 8'hff);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q[7:0], e);
        chk(q[31:24] | q[23:16] | q[15:8], 8'h00);
    endtask

    task automatic to_input;
        wr(OFS_DIR, 8'hff);
        wr(OFS_MODE_HI, 8'h00);
        wr(OFS_MODE_LO, 8'h00);
        wr(OFS_CLEAR, 8'hff);
        wt(4);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd_chk(OFS_DIR, 8'hff);
        rd_chk(OFS_MODE_LO, 8'h00);
        rd_chk(OFS_MODE_HI, 8'h00);
        rd_chk(OFS_CLEAR, 8'h00);
        rd_chk(8'h40, 8'h00);
        rd_chk(OFS_DATA, 8'hff);
        chk(pin_oe_o, 8'h00);
        chk(alt_in_o, 8'hff);
        chk(irq_o, 8'h00);
        // write without byte lane 0 is ignored
        sel_val = 4'h0;
        wr(OFS_DIR, 8'h00);
        sel_val = 4'h1;
        rd_chk(OFS_DIR, 8'hff);
    endtask

    task automatic t_push_pull;
        wr(OFS_DATA, 8'ha5);
        wr(OFS_DIR, 8'h00);
        wt(4);
        chk(pin_oe_o, 8'hff);
        chk(pin_o, 8'ha5);
        rd_chk(OFS_DATA, 8'ha5);
        wr(OFS_DIR, 8'hff);
        wt(2);
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        wt(4);
        chk(pin_oe_o, 8'h00);
        rd_chk(OFS_DATA, 8'h3c);
        ext_en <= 8'h00;
    endtask

    task automatic t_open;
        wr(OFS_DATA, 8'h0f);
        wr(OFS_MODE_LO, 8'hff);
        wr(OFS_DIR, 8'h00);
        wt(4);
        chk(pin_oe_o, 8'hf0);
        chk(pin_i, 8'h0f);
        pull <= 8'h00;
        wr(OFS_DIR, 8'hff);
        wt(4);
        chk(pin_oe_o, 8'h0f);
        chk(pin_i, 8'h0f);
        pull <= 8'hff;
        to_input();
    endtask

    task automatic t_dual;
        // entry order data, high, low, direction
        wr(OFS_DATA, 8'hff);
        wr(OFS_MODE_HI, 8'hff);
        wr(OFS_MODE_LO, 8'h00);
        wr(OFS_DIR, 8'h00);
        wr(OFS_CLEAR, 8'hff);
        wt(4);
        chk(pin_oe_o, 8'h00);
        ext_en <= 8'h04;
        ext_val <= 8'h00;
        wt(6);
        chk(irq_o, 8'h04);
        rd_chk(OFS_PENDING, 8'h04);
        wr(OFS_CLEAR, 8'h04);
        wt(2);
        chk(irq_o, 8'h00);
        ext_en <= 8'h00;
        wt(6);
        chk(irq_o, 8'h04);
        wr(OFS_CLEAR, 8'h04);
        wt(2);
        chk(irq_o, 8'h00);
        wr(OFS_DATA, 8'h00);
        ext_en <= 8'hff;
        wt(6);
        chk(pin_oe_o, 8'h00);
        chk(irq_o, 8'h00);
        ext_en <= 8'h00;
        to_input();
    endtask

    task automatic t_alt;
        pull <= 8'h00;
        wt(4);
        chk(alt_in_o, 8'hff);
        alt_oe <= 8'h0f;
        alt_out <= 8'h05;
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        wr(OFS_DATA, 8'hff);
        wr(OFS_MODE_HI, 8'hff);
        wt(5);
        chk(pin_oe_o, 8'h0f);
        chk(pin_o & 8'h0f, 8'h05);
        chk(alt_in_o, 8'ha5);
        to_input();
        ext_en <= 8'h00;
        alt_oe <= 8'h00;
        pull <= 8'hff;
        wt(4);
        chk(alt_in_o, 8'hff);
    endtask

    task automatic t_edge;
        // pin 0 falling, pin 1 rising
        wr(OFS_DATA, 8'h02);
        wr(OFS_MODE_HI, 8'hff);
        wr(OFS_MODE_LO, 8'hff);
        wr(OFS_DIR, 8'hff);
        wr(OFS_CLEAR, 8'hff);
        wt(4);
        ext_en <= 8'h03;
        ext_val <= 8'h00;
        wt(6);
        chk(irq_o, 8'h01);
        ext_en <= 8'h00;
        wt(6);
        chk(irq_o, 8'h03);
        wt(10);
        chk(irq_o, 8'h03);
        wr(OFS_CLEAR, 8'h03);
        wt(2);
        chk(irq_o, 8'h00);
        to_input();
    endtask

    task automatic t_level;
        wr(OFS_DATA, 8'h00);
        wr(OFS_MODE_HI, 8'hff);
        wr(OFS_MODE_LO, 8'hff);
        wr(OFS_DIR, 8'h00);
        wr(OFS_CLEAR, 8'hff);
        wt(4);
        chk(irq_o, 8'h00);
        ext_en <= 8'h01;
        ext_val <= 8'h00;
        wt(1);
        ext_en <= 8'h00;
        repeat (6)
        begin
            @(posedge clk_i);
            chk(irq_o, 8'h00);
        end
        ext_en <= 8'h01;
        wt(8);
        chk(irq_o, 8'h01);
        ext_en <= 8'h00;
        wt(5);
        chk(irq_o, 8'h00);
        to_input();
    endtask

    // ==========================================================
    // clock, watchdog, main sequence
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial
    begin
        wt(20000);
        n_errors++;
        stop_test();
    end

    initial
    begin
        n_errors = 0;
        comparisons = 0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        sel_val = 4'h1;
        wdat = 32'h00000000;
        alt_out = 8'h00;
        alt_oe = 8'h00;
        ext_en = 8'h00;
        ext_val = 8'h00;
        pull = 8'hff;
        wt(6);
        rst_i <= 1'b0;
        t_reset();
        t_push_pull();
        t_open();
        t_dual();
        t_alt();
        t_edge();
        t_level();
        stop_test();
    end
endmodule
